/* File: include/drd_regs.vh */
// Constants for the request packet decoder
//
// Contract
// - Packet is 24 bits, two 12-bit words
// - Kind code picks format; 0000 is nop
// - Kind 0001 access: read or write
// - Kind 0010 extended: decode trim or power-down
// - Close-refresh packet gives two independent commands
// - Kind 01xx opens a row
// - Kind 1xxx masked write, byte mask
// - Row delay bit postpones open 0/1 cycle
// - Column delay bit postpones access 0/1 cycle
// - Open yields bank, row, subrow select
// - Access yields bank, column, narrow subcolumn
// - Precharge subcode closes bank, delay 0-3
// - Refresh idle; refresh close uses argument bank
// - Refresh open activates refresh row
// - Open-advance also increments refresh row
// - Refresh commands delayed by argument bits 7:6
// - Loads write argument into refresh row
// - Refresh subcode encodings 000 to 111
// - Precharge subcode 100-111 gives delay 0-3
// - Extended codes: trims, trim end, power-down
`ifndef DRD_REGS_VH
`define DRD_REGS_VH

// ==========================================================
// Packet kind codes
`define DRD_KIND_NOP      4'h0
`define DRD_KIND_ACCESS   4'h1
`define DRD_KIND_EXT      4'h2
`define DRD_KIND_CLOSE    4'h3

// ==========================================================
// Field positions in the 24-bit packet
`define DRD_KIND          23:20
`define DRD_ROW_DLY       21
`define DRD_OPEN_BANK     19:17
`define DRD_OPEN_ROW      16:5
`define DRD_OPEN_SUBROW   4:3
`define DRD_COL_WSEL      19
`define DRD_COL_DLY       18
`define DRD_COL_BANK      17:15
`define DRD_COL_ADDR      14:9
`define DRD_COL_SUB       8:5
`define DRD_MSK_BANK      22:20
`define DRD_MSK_ADDR      19:14
`define DRD_MSK_SUB       13:10
`define DRD_MSK_MASK      7:0
`define DRD_EXT_CODE      19:16
`define DRD_PRE_SUB       19:17
`define DRD_PRE_BANK      16:14
`define DRD_REF_SUB       13:11
`define DRD_REF_ARG       10:3

// ==========================================================
// Sub-codes
`define DRD_REF_CLOSE     3'h1
`define DRD_REF_OPEN      3'h2
`define DRD_REF_ADV       3'h3
`define DRD_REF_LOAD_LO   3'h4
`define DRD_REF_LOAD_MID  3'h5
`define DRD_EXT_CUR       4'h8
`define DRD_EXT_IMP       4'h9
`define DRD_EXT_END       4'hA
`define DRD_EXT_SLEEP     4'hC

// ==========================================================
// Register map and reset values
`define DRD_ADDR_CTRL     8'h00
`define DRD_ADDR_STATUS   8'h04
`define DRD_ADDR_COUNT    8'h08
`define DRD_ADDR_LAST     8'h0C
`define DRD_CTRL_RESET    3'h1
`define DRD_RESP_OKAY     2'h0
`define DRD_RESP_SLVERR   2'h2

`endif

/* File: rtl/drd_sync3.v */
// Three-stage pin synchroniser with agreement filter
module drd_sync3 #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         clk,
  input  wire         resetn,
  // Pin side and filtered level
  input  wire [W-1:0] pin,
  output reg  [W-1:0] level
);
  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;

  // Stage one feeds stage two only
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1    <= {W{1'b0}};
      s2    <= {W{1'b0}};
      s3    <= {W{1'b0}};
      level <= {W{1'b0}};
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level <= s3; // Change counts once two stages agree
      end
    end
  end
endmodule // drd_sync3

/* File: rtl/drd_cmd_sched.v */
// Command delay slots: fires a command 0 to 3 request cycles late
module drd_cmd_sched #(
  parameter W = 8
) (
  // Clock and reset
  input  wire         clk,
  input  wire         resetn,
  // Request cycle pulse and new command
  input  wire         tick,
  input  wire         load,
  input  wire [1:0]   delay,
  input  wire [W-1:0] data,
  // Issued command
  output reg          fire,
  output reg  [W-1:0] fire_data
);
  reg [W-1:0] slot_d [1:3];
  reg [3:1]   slot_v;
  integer     i;

  // Shift waiting commands one slot per request cycle
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fire      <= 1'b0;
      fire_data <= {W{1'b0}};
      slot_v    <= 3'h0;
      for (i = 1; i <= 3; i = i + 1) begin
        slot_d[i] <= {W{1'b0}};
      end
    end else begin
      fire <= 1'b0;
      if (load && delay == 2'h0) begin
        fire      <= 1'b1;
        fire_data <= data;
      end else if (tick && slot_v[1]) begin
        fire      <= 1'b1;
        fire_data <= slot_d[1];
      end
      if (tick) begin
        slot_v    <= {1'b0, slot_v[3:2]};
        slot_d[1] <= slot_d[2];
        slot_d[2] <= slot_d[3];
      end
      // New entry lands after the shift
      if (load && delay != 2'h0) begin
        slot_v[delay] <= 1'b1;
        slot_d[delay] <= data;
      end
    end
  end
endmodule // drd_cmd_sched

/* File: rtl/drd_decoder.v */
// Request packet decoder with AXI4-Lite status and control
//
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`include "drd_regs.vh"

module drd_decoder (
  // Clock and reset
  input  wire        clk,
  input  wire        resetn,
  // Request link pins
  input  wire        master_clock_pair,
  input  wire [11:0] request_pins,
  // AXI4-Lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Row open to core
  output wire        row_open,
  output wire [2:0]  activate_slice,
  output wire [11:0] open_row,
  output wire [1:0]  subrow_select,
  // Column access to core
  output wire        col_access,
  output wire        write_select_bit,
  output wire        masked_write,
  output wire [2:0]  column_slice,
  output wire [5:0]  column_address,
  output wire [3:0]  subcolumn_address,
  output wire [7:0]  byte_mask,
  // Precharge to core
  output wire        precharge,
  output wire [2:0]  precharge_slice,
  // Refresh commands to core
  output reg         refresh_close,
  output reg         refresh_open,
  output reg  [2:0]  refresh_bank,
  output reg  [11:0] refresh_row,
  // Maintenance pulses
  output reg         current_trim,
  output reg         impedance_trim,
  output reg         trim_end,
  output reg         power_down_entry
);
  // ========================================================
  // Link capture
  wire        clk_lvl;
  wire [11:0] rq_lvl;
  reg         clk_last;
  reg  [11:0] word_first;
  reg  [23:0] pkt;
  reg         pkt_tick;

  drd_sync3 #(.W(1)) u_sync_clk (
    .clk    (clk),
    .resetn (resetn),
    .pin    (master_clock_pair),
    .level  (clk_lvl)
  );

  drd_sync3 #(.W(12)) u_sync_rq (
    .clk    (clk),
    .resetn (resetn),
    .pin    (request_pins),
    .level  (rq_lvl)
  );

  // First word on rising edge, packet on falling edge
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clk_last   <= 1'b0;
      word_first <= 12'h000;
      pkt        <= 24'h000000;
      pkt_tick   <= 1'b0;
    end else begin
      clk_last <= clk_lvl;
      pkt_tick <= 1'b0;
      if (clk_lvl && !clk_last) begin
        word_first <= rq_lvl;
      end
      if (!clk_lvl && clk_last) begin
        pkt      <= {word_first, rq_lvl};
        pkt_tick <= 1'b1;
      end
    end
  end

  // ========================================================
  // Control and status state
  reg         dec_enable;
  reg  [1:0]  width_mode;
  reg         pd_state;
  reg         trim_active;
  reg  [31:0] pkt_count;
  reg  [23:0] last_pkt;
  reg  [11:0] ref_row_reg;

  // ========================================================
  // Packet decode
  wire [3:0] kind     = pkt[`DRD_KIND];
  wire       go       = pkt_tick && dec_enable;
  wire       is_acc   = (kind == `DRD_KIND_ACCESS);
  wire       is_ext   = (kind == `DRD_KIND_EXT);
  wire       is_close = (kind == `DRD_KIND_CLOSE);
  wire       is_open  = (kind[3:2] == 2'b01);
  wire       is_msk   = kind[3];
  wire [2:0] pre_sub  = pkt[`DRD_PRE_SUB];
  wire [2:0] ref_sub  = pkt[`DRD_REF_SUB];
  wire [7:0] ref_arg  = pkt[`DRD_REF_ARG];
  wire [3:0] ext_code = pkt[`DRD_EXT_CODE];
  // Kind 0000 matches no decode term and so is a nop

  // Row open fields
  wire        opn_load = go && is_open;
  wire [1:0]  opn_dly  = {1'b0, pkt[`DRD_ROW_DLY]};
  wire [16:0] opn_data = {pkt[`DRD_OPEN_BANK], pkt[`DRD_OPEN_ROW],
                          pkt[`DRD_OPEN_SUBROW]};

  // Column access fields, plain or masked
  wire [2:0] c_bank = is_msk ? pkt[`DRD_MSK_BANK] : pkt[`DRD_COL_BANK];
  wire [5:0] c_addr = is_msk ? pkt[`DRD_MSK_ADDR] : pkt[`DRD_COL_ADDR];
  wire [3:0] c_sub  = is_msk ? pkt[`DRD_MSK_SUB]  : pkt[`DRD_COL_SUB];
  // Subcolumn only meaningful for narrow widths
  wire [3:0] c_sub_eff = (width_mode == 2'h0) ? 4'h0 : c_sub;
  // Full mask for unmasked writes
  wire [7:0] c_mask = is_msk ? pkt[`DRD_MSK_MASK] : 8'hFF;
  wire       c_wsel = is_msk | pkt[`DRD_COL_WSEL];
  wire       col_load = go && (is_acc || is_msk);
  wire [1:0] col_dly  = is_msk ? 2'h0 : {1'b0, pkt[`DRD_COL_DLY]};
  wire [22:0] col_data = {c_wsel, is_msk, c_bank, c_addr, c_sub_eff,
                          c_mask};

  // Precharge half of a close-refresh packet
  wire pre_load = go && is_close && pre_sub[2];

  // Refresh half of a close-refresh packet
  wire ref_cmd  = (ref_sub == `DRD_REF_CLOSE) ||
                  (ref_sub == `DRD_REF_OPEN) ||
                  (ref_sub == `DRD_REF_ADV);
  wire ref_load = go && is_close && ref_cmd;
  wire [16:0] ref_data = {ref_sub[1:0], ref_arg[2:0], ref_row_reg};

  // ========================================================
  // Delay slots for each command stream
  wire        ref_fire;
  wire [16:0] ref_fdata;

  drd_cmd_sched #(.W(17)) u_opn (
    .clk       (clk),
    .resetn    (resetn),
    .tick      (pkt_tick),
    .load      (opn_load),
    .delay     (opn_dly),
    .data      (opn_data),
    .fire      (row_open),
    .fire_data ({activate_slice, open_row, subrow_select})
  );

  drd_cmd_sched #(.W(23)) u_col (
    .clk       (clk),
    .resetn    (resetn),
    .tick      (pkt_tick),
    .load      (col_load),
    .delay     (col_dly),
    .data      (col_data),
    .fire      (col_access),
    .fire_data ({write_select_bit, masked_write, column_slice,
                 column_address, subcolumn_address, byte_mask})
  );

  drd_cmd_sched #(.W(3)) u_pre (
    .clk       (clk),
    .resetn    (resetn),
    .tick      (pkt_tick),
    .load      (pre_load),
    .delay     (pre_sub[1:0]),
    .data      (pkt[`DRD_PRE_BANK]),
    .fire      (precharge),
    .fire_data (precharge_slice)
  );

  drd_cmd_sched #(.W(17)) u_ref (
    .clk       (clk),
    .resetn    (resetn),
    .tick      (pkt_tick),
    .load      (ref_load),
    .delay     (ref_arg[7:6]),
    .data      (ref_data),
    .fire      (ref_fire),
    .fire_data (ref_fdata)
  );

  // ========================================================
  // Refresh command outputs and refresh row registers
  wire [1:0] rf_kind = ref_fdata[16:15];

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      refresh_close <= 1'b0;
      refresh_open  <= 1'b0;
      refresh_bank  <= 3'h0;
      refresh_row   <= 12'h000;
      ref_row_reg   <= 12'h000;
    end else begin
      refresh_close <= ref_fire && (rf_kind == 2'h1);
      refresh_open  <= ref_fire && rf_kind[1];
      if (ref_fire) begin
        refresh_bank <= ref_fdata[14:12];
        refresh_row  <= ref_fdata[11:0];
      end
      // Step after advance fires; a load in the same cycle wins on the bits it writes
      if (ref_fire && rf_kind == 2'h3) begin
        ref_row_reg <= ref_row_reg + 12'h001;
      end
      if (go && is_close && ref_sub == `DRD_REF_LOAD_LO) begin
        ref_row_reg[7:0] <= ref_arg;
      end
      if (go && is_close && ref_sub == `DRD_REF_LOAD_MID) begin
        ref_row_reg[11:8] <= ref_arg[3:0];
      end
      // Subcodes 110 and 111 leave everything alone
    end
  end

  // ========================================================
  // Extended commands
  wire ext_go = go && is_ext;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      current_trim     <= 1'b0;
      impedance_trim   <= 1'b0;
      trim_end         <= 1'b0;
      power_down_entry <= 1'b0;
    end else begin
      current_trim     <= ext_go && ext_code == `DRD_EXT_CUR;
      impedance_trim   <= ext_go && ext_code == `DRD_EXT_IMP;
      trim_end         <= ext_go && ext_code == `DRD_EXT_END;
      power_down_entry <= ext_go && ext_code == `DRD_EXT_SLEEP;
      // Other codes give no pulse
    end
  end

  // ========================================================
  // AXI4-Lite write path
  reg  [7:0]  aw_addr;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  wire        aw_take = s_axi_awvalid && s_axi_awready;
  wire        w_take  = s_axi_wvalid && s_axi_wready;
  wire        wr_do   = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire        pd_clr  = wr_do && aw_addr == `DRD_ADDR_STATUS &&
                        w_strb[0] && w_data[0];

  // Hold address and data until both have arrived
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `DRD_RESP_OKAY;
      aw_addr       <= 8'h00;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        if (aw_addr == `DRD_ADDR_CTRL || aw_addr == `DRD_ADDR_STATUS) begin
          s_axi_bresp <= `DRD_RESP_OKAY;
        end else begin
          s_axi_bresp <= `DRD_RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Control register and sticky status
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dec_enable  <= 1'b1;
      width_mode  <= 2'h0;
      pd_state    <= 1'b0;
      trim_active <= 1'b0;
      pkt_count   <= 32'h00000000;
      last_pkt    <= 24'h000000;
    end else begin
      if (wr_do && aw_addr == `DRD_ADDR_CTRL && w_strb[0]) begin
        dec_enable <= w_data[0];
        width_mode <= w_data[2:1];
      end
      // Set wins over a clear in the same cycle
      if (ext_go && ext_code == `DRD_EXT_SLEEP) begin
        pd_state <= 1'b1;
      end else if (pd_clr) begin
        pd_state <= 1'b0;
      end
      if (ext_go && ext_code == `DRD_EXT_CUR) begin
        trim_active <= 1'b1;
      end else if (ext_go && ext_code == `DRD_EXT_END) begin
        trim_active <= 1'b0;
      end
      if (go) begin
        pkt_count <= pkt_count + 32'h00000001;
        last_pkt  <= pkt;
      end
    end
  end

  // ========================================================
  // AXI4-Lite read path
  reg [31:0] rd_mux;

  // Register read select
  always @* begin
    case (s_axi_araddr)
      `DRD_ADDR_CTRL:   rd_mux = {29'h0, width_mode, dec_enable};
      `DRD_ADDR_STATUS: rd_mux = {4'h0, ref_row_reg, 14'h0,
                                  trim_active, pd_state};
      `DRD_ADDR_COUNT:  rd_mux = pkt_count;
      `DRD_ADDR_LAST:   rd_mux = {8'h00, last_pkt};
      default:          rd_mux = 32'h00000000;
    endcase
  end

  // One read in flight; answer the cycle after the address
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `DRD_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_mux;
        if (s_axi_araddr[7:4] == 4'h0 && s_axi_araddr[1:0] == 2'h0) begin
          s_axi_rresp <= `DRD_RESP_OKAY;
        end else begin
          s_axi_rresp <= `DRD_RESP_SLVERR;
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // drd_decoder

/* File: test/drd_decoder_assertions.sv */
// Concurrent checks on the decoder's bus and core command ports
module drd_chk (
  // Clock and reset
  input logic        clk, resetn,
  // Register bus
  input logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input logic        s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
  input logic [7:0]  s_axi_araddr,
  input logic [31:0] s_axi_rdata,
  input logic [1:0]  s_axi_rresp,
  // Core commands
  input logic        row_open, col_access, masked_write, precharge,
  input logic [2:0]  activate_slice, precharge_slice,
  input logic [11:0] open_row,
  input logic [1:0]  subrow_select,
  input logic [7:0]  byte_mask,
  input logic        current_trim, impedance_trim, trim_end, power_down_entry
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ====
  // Register bus answers
  property p_wr_resp;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response late");
  property p_wr_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wr_block: assert property (p_wr_block) else $error("write taken while answer pending");
  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_rd_unmapped;
    s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h0C
      |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not refused");
  // ====
  // Core command pulses and fields
  property p_open_pulse;
    row_open |=> !row_open;
  endproperty
  a_open_pulse: assert property (p_open_pulse) else $error("open pulse too long");
  property p_open_hold;
    !row_open |-> $stable({activate_slice, open_row, subrow_select});
  endproperty
  a_open_hold: assert property (p_open_hold) else $error("open fields moved");
  property p_mask_full;
    col_access && !masked_write |-> byte_mask == 8'hFF;
  endproperty
  a_mask_full: assert property (p_mask_full) else $error("unmasked write masked");
  property p_pre_hold;
    !precharge |-> $stable(precharge_slice);
  endproperty
  a_pre_hold: assert property (p_pre_hold) else $error("precharge bank moved");
  property p_ext_one;
    $onehot0({current_trim, impedance_trim, trim_end, power_down_entry});
  endproperty
  a_ext_one: assert property (p_ext_one) else $error("two maintenance pulses");
  property p_trim_pulse;
    current_trim |=> !current_trim [*3];
  endproperty
  a_trim_pulse: assert property (p_trim_pulse) else $error("trim pulse repeated");
endmodule // drd_chk

bind drd_decoder drd_chk u_chk (.*);

/* File: test/drd_ctrl_model.sv */
// Memory controller model driving the request link
module drd_ctrl_model (
  // Reference clock for frame start
  input  logic        clk,
  // Request link
  output logic        master_clock_pair,
  output logic [11:0] request_pins
);
  timeunit 1ns;
  timeprecision 100ps;
  // Frames sent, for the packet count check
  int          n_sent = 0;
  // Link idle before the first frame
  initial begin
    master_clock_pair = 1'b0;
    request_pins = 12'hFFF;
  end
  // One 48 ns frame: word on rising, word on falling edge
  task automatic send(input logic [23:0] pkt);
    @(posedge clk);
    n_sent++;
    #1.7;
    request_pins = pkt[23:12];
    #12;
    master_clock_pair = 1'b1;
    #12;
    request_pins = pkt[11:0];
    #12;
    master_clock_pair = 1'b0;
    #12;
    request_pins = ~pkt[11:0]; // Released: stale bits must not pass
  endtask
endmodule // drd_ctrl_model

/* File: test/drd_decoder_tb.sv */
// Self-checking bench for the request packet decoder
module drd_decoder_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ====
  // Design signals and bench state
  logic        clk, resetn, master_clock_pair;
  logic [11:0] request_pins, open_row, refresh_row;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, byte_mask;
  logic [31:0] s_axi_wdata, s_axi_rdata, r, rd;
  logic [3:0]  s_axi_wstrb, subcolumn_address;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, row_open, col_access, write_select_bit;
  logic        masked_write, precharge, refresh_close, refresh_open;
  logic        current_trim, impedance_trim, trim_end, power_down_entry;
  logic [1:0]  s_axi_bresp, s_axi_rresp, subrow_select, rr;
  logic [2:0]  activate_slice, column_slice, precharge_slice, refresh_bank, pre_f;
  logic [5:0]  column_address;
  logic [8:0]  pl;
  logic [22:0] col_f;
  logic [16:0] row_f;
  logic [14:0] ref_f;
  logic [23:0] p;
  logic [11:0] rw;
  int          n_errors = 0, checked = 0, seed = 5, cyc = 0, b;
  int          cnt[10];

  drd_decoder dut (.*);
  drd_ctrl_model u_ctrl (.clk(clk), .master_clock_pair(master_clock_pair),
                         .request_pins(request_pins));
  // Clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Pulse counters and field capture
  assign pl = {power_down_entry, trim_end, impedance_trim, current_trim,
               refresh_open, refresh_close, precharge, col_access, row_open};
  always @(posedge clk) begin
    for (int i = 0; i < 9; i++) if (pl[i] === 1'b1) begin cnt[i]++; cnt[9]++; end
    if (row_open) row_f <= {activate_slice, open_row, subrow_select};
    if (col_access) col_f <= {write_select_bit, masked_write, column_slice,
                              column_address, subcolumn_address, byte_mask};
    if (precharge) pre_f <= precharge_slice;
    if (refresh_open || refresh_close) ref_f <= {refresh_bank, refresh_row};
  end
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin n_errors++; print_verdict; end
  end
  // ====
  // Tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", e, s_axi_bresp);
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rr = s_axi_rresp;
  endtask
  // Send a packet, idle frames walk any delay; pulse only when due
  task automatic run(input logic [23:0] pk, input int k, input int dl);
    int bs = cnt[k];
    int m = dl < 0 ? 0 : dl;
    p = pk;
    u_ctrl.send(pk);
    for (int d = 0; d <= m; d++) begin
      if (d > 0) u_ctrl.send(24'h0);
      repeat (12) @(posedge clk);
      chk("pulses", 32'(d == dl), 32'(cnt[k] - bs));
    end
  endtask
  function automatic int ext_k(input int c);
    case (c)
      8: return 5;
      9: return 6;
      10: return 7;
      12: return 8;
      default: return 9;
    endcase
  endfunction
  // ====
  // Main sequence
  initial begin
    resetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    rdr(8'h00); chk("ctrl", 32'h1, rd);
    rdr(8'h04); chk("status", 32'h0, rd);
    wr(8'h00, 32'h3, 2'h0);
    wr(8'h20, 32'h0, 2'h2);
    rdr(8'h10); chk("rresp", 32'h2, {30'h0, rr});
    rdr(8'h00); chk("ctrl", 32'h3, rd);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      run({2'b01, i[0], r[20:0]}, 0, i[0]);
      chk("row", r[19:3], row_f);
      r = $random(seed);
      run({4'h1, i[0], i[1], r[17:0]}, 1, i[1]);
      chk("col", {i[0], 1'b0, r[17:5], 8'hFF}, col_f);
      r = $random(seed);
      run({1'b1, r[22:0]}, 1, 0);
      chk("masked", {1'b1, r[22:10], r[7:0]}, col_f[21:0]);
    end
    $display("test row and column done");
    for (int i = 7; i > 0; i--) begin
      r = $random(seed);
      run({4'h3, i[2:0], r[16:14], 3'h0, r[10:0]}, i > 3 ? 2 : 9, i > 3 ? i - 4 : -1);
      if (i > 3) chk("pre", r[16:14], pre_f);
    end
    rdr(8'h0C); chk("last", p, rd);
    r = $random(seed);
    rw = r[11:0];
    run({4'h3, 6'h0, 3'h4, r[7:0], 3'h0}, 9, -1);
    run({4'h3, 6'h0, 3'h5, r[15:8], 3'h0}, 9, -1);
    for (int i = 6; i < 8; i++) run({4'h3, 6'h0, i[2:0], r[23:16], 3'h0}, 9, -1);
    rdr(8'h04); chk("rrow", rw, rd[27:16]);
    run({4'h3, 6'h0, 3'h2, 2'h2, r[21:19], 3'h5, 3'h0}, 4, 2);
    chk("ref", {3'h5, rw}, ref_f);
    run({4'h3, 6'h0, 3'h3, 2'h3, 3'h0, 3'h2, 3'h0}, 4, 3);
    chk("ref", {3'h2, rw}, ref_f);
    rdr(8'h04); chk("rrow", 12'(rw + 12'h1), rd[27:16]);
    b = cnt[2];
    run({4'h3, 3'h4, 3'h6, 3'h1, 2'h1, 3'h0, 3'h3, 3'h0}, 3, 1);
    chk("pre", 32'h1, 32'(cnt[2] - b));
    chk("pre", 32'h6, pre_f);
    chk("rbank", 32'h3, ref_f[14:12]);
    run({4'h3, 3'h0, r[26:24], 3'h0, r[7:0], 3'h0}, 9, -1);
    run({4'h0, r[19:0]}, 9, -1);
    $display("test close and refresh done");
    for (int c = 0; c < 16; c++) begin
      b = cnt[9];
      run({4'h2, c[3:0], r[15:0]}, ext_k(c), ext_k(c) == 9 ? -1 : 0);
      chk("ext", 32'(ext_k(c) != 9), 32'(cnt[9] - b));
      if (c == 8) begin
        rdr(8'h04);
        chk("trim", 32'h1, rd[1]);
      end
    end
    rdr(8'h04); chk("pdn", 32'h1, rd[1:0]);
    wr(8'h04, 32'h1, 2'h0);
    rdr(8'h04); chk("pdn", 32'h0, rd[0]);
    wr(8'h00, 32'h1, 2'h0);
    run({4'h1, 2'b10, r[17:0]}, 1, 0);
    chk("col", {2'b10, r[17:9], 4'h0, 8'hFF}, col_f);
    rdr(8'h08); chk("count", u_ctrl.n_sent, rd);
    wr(8'h00, 32'h2, 2'h0);
    run({2'b01, 1'b0, r[20:0]}, 9, -1);
    rdr(8'h08); chk("count", u_ctrl.n_sent - 1, rd);
    $display("test extended and disable done");
    print_verdict;
  end
endmodule // drd_decoder_tb
